// file: inc/ccr_consts.vh
// Constants for the CAN controller control segment and reset state
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH
// ---------------------------------------------------------------
// Register offsets (low five address bits)
// ---------------------------------------------------------------
`define CCR_ADDR_W      5
`define CCR_OFF_CTRL    5'h00
`define CCR_OFF_CMD     5'h01
`define CCR_OFF_STAT    5'h02
`define CCR_OFF_IRQ     5'h03
`define CCR_OFF_ACODE   5'h04
`define CCR_OFF_AMASK   5'h05
`define CCR_OFF_TIM0    5'h06
`define CCR_OFF_TIM1    5'h07
`define CCR_OFF_OUTC    5'h08
`define CCR_OFF_TEST    5'h09
`define CCR_OFF_CDIV    5'h1F
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CCR_CR_RESET_REQ    0
`define CCR_CR_RX_IE        1
`define CCR_CR_TX_IE        2
`define CCR_CR_ERR_IE       3
`define CCR_CR_OVR_IE       4
`define CCR_CR_RSV5         5
`define CCR_CR_RSV6         6
`define CCR_CR_RSV7         7
`define CCR_CMD_SEND        0
`define CCR_CMD_ABORT       1
`define CCR_CMD_RELEASE     2
`define CCR_CMD_CLR_OVR     3
`define CCR_CMD_SLEEP       4
`define CCR_CDIV_MODE       7
`define CCR_CDIV_CBP        6
// ---------------------------------------------------------------
// Reset and read values
// ---------------------------------------------------------------
`define CCR_ALL_ONES        8'hFF
`define CCR_CTRL_HW_RST     8'h21
`define CCR_IRQ_RSV_ONES    3'h7
`define CCR_SETUP_RST       8'h00
`endif

// file: hw/ccr_setup_mem.v
// Setup register store: acceptance, bus timing and output control
`timescale 1ns/1ps
`include "ccr_consts.vh"
module ccr_setup_mem (
    input  wire       i_clk_sys,   // System clock
    input  wire       i_reset_n,   // Async reset, active low
    input  wire       i_we,        // Write strobe
    input  wire [2:0] i_idx,       // Word index 0..4
    input  wire [7:0] i_wdata,     // Write data
    output reg  [7:0] o_rdata      // Registered read data
);
    reg  [7:0] mem_r [0:4];
    integer    k;

    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (k = 0; k < 5; k = k + 1) begin
                mem_r[k] <= `CCR_SETUP_RST;
            end
            o_rdata <= `CCR_SETUP_RST;
        end else begin
            if (i_we && i_idx < 3'h5) begin
                mem_r[i_idx] <= i_wdata;
            end
            o_rdata <= (i_idx < 3'h5) ? mem_r[i_idx] : `CCR_ALL_ONES;
        end
    end
endmodule // ccr_setup_mem

// file: hw/ccr_ctrl_reset.v
// Control segment registers with reset mode entry and exit
`timescale 1ns/1ps
`include "ccr_consts.vh"
module ccr_ctrl_reset (
    input  wire       i_clk_sys,       // System clock 100 MHz
    input  wire       i_reset_n,       // Async hardware reset, low
    input  wire [7:0] i_addr,          // Host address
    input  wire       i_cs,            // Chip select, one-cycle access
    input  wire       i_wr,            // 1 write, 0 read
    input  wire [7:0] i_wdata,         // Write data
    output reg  [7:0] o_rdata,         // Read data, valid next cycle
    output reg        o_rvalid,        // Read data valid pulse
    input  wire       i_bus_off,       // Bus-off event from core
    input  wire       i_err_warn,      // Error warning level from core
    input  wire       i_tx_busy,       // Core transmitting
    input  wire       i_rx_busy,       // Core receiving
    input  wire       i_tx_done,       // Transmission completed pulse
    input  wire       i_rx_frame,      // Frame stored pulse
    input  wire       i_overrun,       // Overrun pulse
    input  wire       i_wakeup,        // Wake-up pulse
    input  wire       i_err_change,    // Error state change pulse
    output reg        o_reset_mode,    // Core held in reset mode
    output reg        o_abort_frame,   // Abort current frame pulse
    output reg        o_send_frame,    // Send request pulse
    output reg        o_abort_send,    // Abort transmission pulse
    output reg        o_release_rx,    // Release receive buffer pulse
    output reg        o_sleep,         // Sleep requested level
    output reg        o_ctrl_mode,     // Controller mode bit
    output reg        o_cmp_bypass     // Comparator bypass bit
);
    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    reg  [8:0] sync1_r;
    reg  [8:0] sync2_r;
    wire [8:0] raw_in = {i_bus_off, i_err_warn, i_tx_busy, i_rx_busy,
                         i_tx_done, i_rx_frame, i_overrun, i_wakeup,
                         i_err_change};
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_r <= 9'h000;
            sync2_r <= 9'h000;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end
    wire s_bus_off  = sync2_r[8];
    wire s_err_warn = sync2_r[7];
    wire s_tx_busy  = sync2_r[6];
    wire s_rx_busy  = sync2_r[5];
    reg  [4:0] ev_d_r;
    wire [4:0] ev_rise = sync2_r[4:0] & ~ev_d_r;
    wire e_tx_done  = ev_rise[4];
    wire e_rx_frame = ev_rise[3];
    wire e_overrun  = ev_rise[2];
    wire e_wakeup   = ev_rise[1];
    wire e_err_chg  = ev_rise[0];

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    function [4:0] low_addr;
        input [7:0] a;
        begin
            low_addr = a[4:0];
        end
    endfunction

    wire [4:0] a5   = low_addr(i_addr);
    wire       wr   = i_cs & i_wr;
    wire       rd   = i_cs & ~i_wr;
    wire       setup_sel = (a5 >= `CCR_OFF_ACODE) && (a5 <= `CCR_OFF_OUTC);

    // ---------------------------------------------------------------
    // State registers
    // ---------------------------------------------------------------
    reg        reset_req_r;
    reg        ctrl_rsv6_r;
    reg  [3:0] irq_en_r;
    reg        bus_off_flag_r, error_warn_flag_r, tx_complete_flag_r;
    reg        tx_buffer_free_r, overrun_flag_r, rx_buffer_full_r;
    reg        wakeup_flag_r, overrun_event_r, error_flag_r;
    reg        tx_done_flag_r, rx_done_flag_r;
    reg  [5:0] cdiv_low_r;
    reg  [7:0] test_r;
    reg        bus_off_d_r;
    reg        rd_irq_r;
    reg        rd_setup_r;
    reg  [7:0] rd_mux_r;

    wire bus_off_rise = s_bus_off & ~bus_off_d_r;
    wire ctrl_wr      = wr && a5 == `CCR_OFF_CTRL;
    // Reset request after this edge; a bus-off rise beats a host clear
    wire rr_nxt       = ctrl_wr ? (i_wdata[`CCR_CR_RESET_REQ] | bus_off_rise)
                                : (reset_req_r | bus_off_rise);
    wire sw_set_rr    = wr && a5 == `CCR_OFF_CTRL
                        && i_wdata[`CCR_CR_RESET_REQ];
    // Reset mode applies from the cycle after it is requested
    wire enter_reset  = (sw_set_rr | bus_off_rise) & ~reset_req_r;
    wire cmd_wr       = wr && a5 == `CCR_OFF_CMD && !reset_req_r;
    wire [7:0] cmd    = cmd_wr ? i_wdata : 8'h00;
    wire rr_now       = reset_req_r | sw_set_rr | bus_off_rise;

    wire [7:0] ctrl_rd = {1'b0, ctrl_rsv6_r, 1'b1, irq_en_r,
                          reset_req_r};
    wire [7:0] stat_rd = {bus_off_flag_r, error_warn_flag_r,
                          s_tx_busy & ~reset_req_r,
                          s_rx_busy & ~reset_req_r,
                          tx_complete_flag_r, tx_buffer_free_r,
                          overrun_flag_r, rx_buffer_full_r};
    wire [7:0] irq_rd  = {`CCR_IRQ_RSV_ONES, wakeup_flag_r,
                          overrun_event_r, error_flag_r,
                          tx_done_flag_r, rx_done_flag_r};

    // ---------------------------------------------------------------
    // Setup register store
    // ---------------------------------------------------------------
    wire [7:0] setup_rdata;
    wire [2:0] setup_idx = a5[2:0] - 3'h4;
    ccr_setup_mem u_setup (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_we      (wr & setup_sel & reset_req_r),
        .i_idx     (setup_sel ? setup_idx : 3'h7),
        .i_wdata   (i_wdata),
        .o_rdata   (setup_rdata)
    );

    // ---------------------------------------------------------------
    // Control, status and flags
    // ---------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reset_req_r        <= 1'b1;
            ctrl_rsv6_r        <= 1'b0;
            irq_en_r           <= 4'h0;
            bus_off_flag_r     <= 1'b0;
            error_warn_flag_r  <= 1'b0;
            tx_complete_flag_r <= 1'b1;
            tx_buffer_free_r   <= 1'b1;
            overrun_flag_r     <= 1'b0;
            rx_buffer_full_r   <= 1'b0;
            wakeup_flag_r      <= 1'b0;
            overrun_event_r    <= 1'b0;
            error_flag_r       <= 1'b0;
            tx_done_flag_r     <= 1'b0;
            rx_done_flag_r     <= 1'b0;
            o_ctrl_mode        <= 1'b0;
            o_cmp_bypass       <= 1'b0;
            cdiv_low_r         <= 6'h00;
            test_r             <= 8'h00;
            bus_off_d_r        <= 1'b0;
            ev_d_r             <= 5'h00;
        end else begin
            ev_d_r      <= sync2_r[4:0];
            bus_off_d_r <= s_bus_off;
            // Control register; reset request kept while bus-off newly hit
            if (wr && a5 == `CCR_OFF_CTRL) begin
                reset_req_r <= rr_nxt;
                ctrl_rsv6_r <= i_wdata[`CCR_CR_RSV6];
                irq_en_r    <= i_wdata[`CCR_CR_OVR_IE:`CCR_CR_RX_IE];
            end else if (bus_off_rise) begin
                reset_req_r <= 1'b1;
            end
            if (wr && a5 == `CCR_OFF_CDIV) begin
                cdiv_low_r <= i_wdata[5:0];
                if (reset_req_r) begin
                    o_ctrl_mode  <= i_wdata[`CCR_CDIV_MODE];
                    o_cmp_bypass <= i_wdata[`CCR_CDIV_CBP];
                end
            end
            if (wr && a5 == `CCR_OFF_TEST) begin
                test_r <= i_wdata;
            end
            // Status bits from the core
            if (s_bus_off) begin
                bus_off_flag_r <= 1'b1;
            end else if (!reset_req_r) begin
                bus_off_flag_r <= 1'b0;
            end
            error_warn_flag_r <= s_err_warn;
            if (rr_now) begin
                tx_buffer_free_r <= 1'b1;
                overrun_flag_r   <= 1'b0;
                rx_buffer_full_r <= 1'b0;
                wakeup_flag_r    <= 1'b0;
                overrun_event_r  <= 1'b0;
                tx_done_flag_r   <= 1'b0;
                rx_done_flag_r   <= 1'b0;
                if (e_err_chg && irq_en_r[2]) begin
                    error_flag_r <= 1'b1;
                end else if (rd_irq_r) begin
                    error_flag_r <= 1'b0;
                end
            end else begin
                if (cmd[`CCR_CMD_SEND]) begin
                    tx_buffer_free_r   <= 1'b0;
                    tx_complete_flag_r <= 1'b0;
                end else if (e_tx_done) begin
                    tx_buffer_free_r   <= 1'b1;
                    tx_complete_flag_r <= 1'b1;
                end
                if (e_rx_frame) begin
                    rx_buffer_full_r <= 1'b1;
                end else if (cmd[`CCR_CMD_RELEASE]) begin
                    rx_buffer_full_r <= 1'b0;
                end
                if (e_overrun) begin
                    overrun_flag_r <= 1'b1;
                end else if (cmd[`CCR_CMD_CLR_OVR]) begin
                    overrun_flag_r <= 1'b0;
                end
                // Interrupt flags: set wins over clear-on-read
                wakeup_flag_r   <= e_wakeup | (wakeup_flag_r & ~rd_irq_r);
                overrun_event_r <= (e_overrun & irq_en_r[3])
                                   | (overrun_event_r & ~rd_irq_r);
                error_flag_r    <= (e_err_chg & irq_en_r[2])
                                   | (error_flag_r & ~rd_irq_r);
                tx_done_flag_r  <= (e_tx_done & irq_en_r[1])
                                   | (tx_done_flag_r & ~rd_irq_r);
                rx_done_flag_r  <= (e_rx_frame & irq_en_r[0])
                                   | (rx_done_flag_r & ~rd_irq_r);
            end
        end
    end

    // ---------------------------------------------------------------
    // Core strobes
    // ---------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reset_mode  <= 1'b1;
            o_abort_frame <= 1'b0;
            o_send_frame  <= 1'b0;
            o_abort_send  <= 1'b0;
            o_release_rx  <= 1'b0;
            o_sleep       <= 1'b0;
        end else begin
            o_reset_mode  <= rr_nxt;
            o_abort_frame <= enter_reset;
            o_send_frame  <= cmd[`CCR_CMD_SEND];
            o_abort_send  <= cmd[`CCR_CMD_ABORT];
            o_release_rx  <= cmd[`CCR_CMD_RELEASE] | enter_reset;
            if (rr_now) begin
                o_sleep <= 1'b0;
            end else if (cmd_wr) begin
                o_sleep <= i_wdata[`CCR_CMD_SLEEP];
            end
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_irq_r   <= 1'b0;
            rd_setup_r <= 1'b0;
            rd_mux_r   <= 8'h00;
            o_rvalid   <= 1'b0;
        end else begin
            rd_irq_r   <= rd && a5 == `CCR_OFF_IRQ;
            rd_setup_r <= rd && setup_sel && reset_req_r;
            o_rvalid   <= rd;
            case (a5)
                `CCR_OFF_CTRL: rd_mux_r <= ctrl_rd;
                `CCR_OFF_CMD:  rd_mux_r <= `CCR_ALL_ONES;
                `CCR_OFF_STAT: rd_mux_r <= stat_rd;
                `CCR_OFF_IRQ:  rd_mux_r <= irq_rd;
                `CCR_OFF_TEST: rd_mux_r <= test_r;
                `CCR_OFF_CDIV: rd_mux_r <= {o_ctrl_mode, o_cmp_bypass,
                                            cdiv_low_r};
                default:       rd_mux_r <= `CCR_ALL_ONES;
            endcase
        end
    end

    // One cycle after the access; setup data come from the store only in reset mode
    always @* begin
        o_rdata = rd_setup_r ? setup_rdata : rd_mux_r;
    end
endmodule // ccr_ctrl_reset

// file: tb/ccr_host_model.sv
// Host bus master issuing one-cycle register accesses
`timescale 1ns/1ps
module ccr_host_model (
    input  wire       i_clk_sys, // System clock
    output reg        o_cs,      // Chip select
    output reg        o_wr,      // Write when high
    output reg  [7:0] o_addr,    // Host address
    output reg  [7:0] o_wdata    // Write data
);
    initial begin
        o_cs = 1'b0;
        o_wr = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    // Offset 9 is never addressed by this host
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        begin
            @(posedge i_clk_sys);
            o_cs    <= 1'b1;
            o_wr    <= w;
            o_addr  <= a;
            o_wdata <= d;
            @(posedge i_clk_sys);
            o_cs    <= 1'b0;
            // Released lines flip so no stale value looks valid
            o_addr  <= ~a;
            o_wdata <= ~d;
        end
    endtask
endmodule // ccr_host_model

// file: tb/ccr_ctrl_reset_props.sv
// Port checker for the control segment reset behaviour
`timescale 1ns/1ps
module ccr_ctrl_reset_props (
    input wire       i_clk_sys,     // System clock
    input wire       i_reset_n,     // Hardware reset, low
    input wire [7:0] i_addr,        // Host address
    input wire       i_cs,          // Chip select
    input wire       i_wr,          // Write strobe
    input wire [7:0] i_wdata,       // Write data
    input wire [7:0] o_rdata,       // Read data
    input wire       i_bus_off,     // Bus-off level
    input wire       o_reset_mode,  // Reset mode
    input wire       o_abort_frame, // Frame abort
    input wire       o_send_frame,  // Send pulse
    input wire       o_abort_send,  // Abort pulse
    input wire       o_release_rx,  // Release pulse
    input wire       o_ctrl_mode,   // Mode bit
    input wire       o_cmp_bypass   // Bypass bit
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    wire rd_a = i_cs && !i_wr;
    wire wr_a = i_cs && i_wr;
    wire [4:0] off = i_addr[4:0];
    a_ctrl_rsv_bits: assert property (rd_a && off == 5'h00 && o_reset_mode
        |=> o_rdata[7] == 1'b0 && o_rdata[5] == 1'b1) else $error("ctrl bits");
    a_cmd_all_ones: assert property (rd_a && off == 5'h01
        |=> o_rdata == 8'hFF) else $error("command read");
    a_irq_rsv_ones: assert property (rd_a && off == 5'h03
        |=> o_rdata[7:5] == 3'h7) else $error("irq reserved");
    a_setup_hidden: assert property (rd_a && off >= 5'h04 && off <= 5'h08
        && !o_reset_mode |=> o_rdata == 8'hFF) else $error("setup read");
    a_no_cmd_rst: assert property (wr_a && off == 5'h01 && o_reset_mode
        |=> !o_send_frame && !o_abort_send) else $error("command in reset");
    a_status_idle: assert property (rd_a && off == 5'h02 && o_reset_mode
        |=> o_rdata[5:4] == 2'b00 && o_rdata[2:0] == 3'b100)
        else $error("status in reset");
    a_exit_on_clear: assert property (wr_a && off == 5'h00 && !i_wdata[0]
        && o_reset_mode && !i_bus_off && !$past(i_bus_off)
        && !$past(i_bus_off, 2) && !$past(i_bus_off, 3)
        |=> !o_reset_mode) else $error("no exit");
    a_enter_abort: assert property (wr_a && off == 5'h00 && i_wdata[0]
        && !o_reset_mode |=> o_reset_mode && o_abort_frame && o_release_rx)
        else $error("no entry");
    a_mode_bits_lock: assert property (wr_a && off == 5'h1F && !o_reset_mode
        |=> $stable(o_ctrl_mode) && $stable(o_cmp_bypass))
        else $error("mode bits changed");
    a_busoff_enter: assert property ($rose(i_bus_off)
        |-> ##[1:4] o_reset_mode) else $error("bus-off entry");
    a_hw_rst_mode: assert property ($rose(i_reset_n) |-> o_reset_mode)
        else $error("reset mode after reset");
    c_sw_entry: cover property (o_abort_frame);
    c_send: cover property (o_send_frame);
    c_busoff: cover property ($rose(i_bus_off));
endmodule // ccr_ctrl_reset_props

// file: tb/ccr_ctrl_reset_tb.sv
// Self-checking bench for the control segment reset behaviour
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    mismatches++; $display("mismatch %s exp %h got %h", n, e, g); end end
module ccr_ctrl_reset_tb;
    reg        clk, rst_n, bus_off, err_warn, tx_busy, rx_busy;
    reg  [4:0] ev;
    wire       cs, wr, rvalid, mode, abrt, send, abs, rel, slp, cm, comparator_bypass;
    wire [7:0] addr, wdata, rdata;
    int        mismatches, total_checks, cycles;
    logic [7:0] expq[$];
    logic [7:0] d;
    logic [7:0] exp_v;
    ccr_host_model i_ccr_host_model (.i_clk_sys(clk), .o_cs(cs), .o_wr(wr),
        .o_addr(addr), .o_wdata(wdata));
    ccr_ctrl_reset i_ccr_ctrl_reset (.i_clk_sys(clk), .i_reset_n(rst_n),
        .i_addr(addr), .i_cs(cs), .i_wr(wr), .i_wdata(wdata),
        .o_rdata(rdata), .o_rvalid(rvalid), .i_bus_off(bus_off),
        .i_err_warn(err_warn), .i_tx_busy(tx_busy), .i_rx_busy(rx_busy),
        .i_tx_done(ev[1]), .i_rx_frame(ev[2]), .i_overrun(ev[3]),
        .i_wakeup(ev[0]), .i_err_change(ev[4]), .o_reset_mode(mode),
        .o_abort_frame(abrt), .o_send_frame(send), .o_abort_send(abs),
        .o_release_rx(rel), .o_sleep(slp), .o_ctrl_mode(cm),
        .o_cmp_bypass(comparator_bypass));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        i_ccr_host_model.acc(1'b0, a, 8'h00);
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] v);
        i_ccr_host_model.acc(1'b1, a, v);
        #1;
    endtask
    task automatic hw_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // Read results are taken off the note queue in arrival order
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            if (expq.size() == 0) begin
                `CHK("unexpected read", 1'b0, 1'b1)
            end else begin
                exp_v = expq.pop_front();
                `CHK("rdata", exp_v, rdata)
            end
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        {rst_n, bus_off, err_warn, tx_busy, rx_busy, ev} = '0;
        void'($urandom(42));
        hw_reset();
        d = $urandom;
        rd(8'h00, 8'h21);
        rd({d[7:5], 5'h00}, 8'h21);
        rd(8'h02, 8'h0C);
        rd(8'h03, 8'hE0);
        `CHK("reset_mode", 1'b1, mode)
        $display("test hw_reset done");
        wrr(8'h04, d);
        rd(8'h04, d);
        wrr(8'h1F, 8'hC0);
        `CHK("mode bits", 2'b11, {cm, comparator_bypass})
        wrr(8'h00, 8'h00);
        `CHK("reset_mode", 1'b0, mode)
        rd(8'h04, 8'hFF);
        rd(8'h01, 8'hFF);
        wrr(8'h1F, 8'h00);
        `CHK("mode bits", 2'b11, {cm, comparator_bypass})
        wrr(8'h01, 8'h01);
        `CHK("send", 1'b1, send)
        wrr(8'h01, 8'h16);
        `CHK("cmd strobes", 3'b111, {abs, rel, slp})
        $display("test operating done");
        wrr(8'h00, 8'h08);
        ev <= 5'h11;
        cyc(1);
        ev <= 5'h00;
        cyc(4);
        wrr(8'h00, 8'h09);
        `CHK("entry", 4'b1110, {mode, abrt, rel, slp})
        tx_busy <= 1'b1;
        rx_busy <= 1'b1;
        cyc(4);
        rd(8'h02, 8'h04);
        rd(8'h03, 8'hE4);
        wrr(8'h01, 8'h01);
        `CHK("send", 1'b0, send)
        tx_busy <= 1'b0;
        rx_busy <= 1'b0;
        $display("test sw_reset done");
        wrr(8'h00, 8'h00);
        bus_off <= 1'b1;
        cyc(5);
        `CHK("reset_mode", 1'b1, mode)
        rd(8'h02, 8'h84);
        bus_off <= 1'b0;
        cyc(4);
        wrr(8'h00, 8'h00);
        `CHK("reset_mode", 1'b0, mode)
        $display("test bus_off done");
        hw_reset();
        rd(8'h00, 8'h21);
        rd(8'h02, 8'h0C);
        rd(8'h03, 8'hE0);
        cyc(4);
        `CHK("queue empty", 0, expq.size())
        $display("test second_reset done");
        finish_test();
    end
endmodule // ccr_ctrl_reset_tb
bind ccr_ctrl_reset ccr_ctrl_reset_props i_ccr_ctrl_reset_props (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_cs(i_cs), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_bus_off(i_bus_off), .o_reset_mode(o_reset_mode),
    .o_abort_frame(o_abort_frame), .o_send_frame(o_send_frame),
    .o_abort_send(o_abort_send), .o_release_rx(o_release_rx),
    .o_ctrl_mode(o_ctrl_mode), .o_cmp_bypass(o_cmp_bypass));
